// [core/acbd_pkg.sv]
// How it works
// - Base address is any 14-bit byte address.
// - Depth holds size minus one; end = base+depth.
// - Tallies start zero; compare with offsets for empty/full.
// - Read address is base plus read offset.
// - Write address is base plus write offset.
// - Read code flags fault reply and break.
// - Write code flags command protocol error.
`default_nettype none
package acbd_pkg;
	localparam int BA_W    = 14;
	localparam int DEPTH_W = 12;
	localparam int TALLY_W = 8;
	localparam int STATE_W = 5;
	localparam int EVT_W   = 5;
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;

	localparam logic [ADDR_W-1:0] OFF_BASE    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DEPTH   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RD_OFS  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_WR_OFS  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_TALLY   = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATE   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STS = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN  = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_FLAGS   = 8'h24;

	// Second field of the packed tally and state registers starts here.
	localparam int HI_LSB = 8;
	localparam int STATE_PROTO_BIT = 2;
	localparam int STATE_BREAK_BIT = 4;
	localparam int FLAG_EMPTY_BIT  = 0;
	localparam int FLAG_FULL_BIT   = 1;

	localparam int EVT_RX_FAULT = 0;
	localparam int EVT_RX_BREAK = 1;
	localparam int EVT_WR_FAULT = 2;
	localparam int EVT_RD_PKT   = 3;
	localparam int EVT_WR_PKT   = 4;

	localparam logic [DEPTH_W-1:0] OFS_RESET   = 12'h000;
	localparam logic [TALLY_W-1:0] TALLY_RESET = 8'h00;
	localparam logic [STATE_W-1:0] STATE_RESET = 5'h00;
	localparam logic [EVT_W-1:0]   EVT_RESET   = 5'h00;

	typedef logic [DEPTH_W-1:0] acbd_ofs_t;
	typedef logic [TALLY_W-1:0] acbd_tally_t;
endpackage
`default_nettype wire

// [core/acbd_ring_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface acbd_ring_if;
	import acbd_pkg::*;
	acbd_ofs_t   depth;
	logic        advance;
	logic        pkt_done;
	logic        sw_ofs_we;
	acbd_ofs_t   sw_ofs;
	logic        sw_tally_we;
	acbd_tally_t sw_tally;
	acbd_ofs_t   ofs;
	acbd_tally_t tally;

	modport ring (input depth, advance, pkt_done, sw_ofs_we, sw_ofs,
		sw_tally_we, sw_tally, output ofs, tally);
	modport ctl (output depth, advance, pkt_done, sw_ofs_we, sw_ofs,
		sw_tally_we, sw_tally, input ofs, tally);
endinterface
`default_nettype wire

// [core/acbd_ring.sv]
`timescale 1ns/1ns
`default_nettype none
module acbd_ring
	import acbd_pkg::*;
(
	input  wire logic clock, // System clock.
	input  wire logic rst,   // Synchronous reset, active high.
	acbd_ring_if.ring r      // One ring pointer and its packet tally.
);
	acbd_ofs_t   ofs_q;
	acbd_tally_t tally_q;

	assign r.ofs   = ofs_q;
	assign r.tally = tally_q;

	// A software write wins over a byte step in the same cycle, since
	// software only rewrites a pointer while the channel is idle.
	always_ff @(posedge clock)
		if (rst)
			ofs_q <= OFS_RESET;
		else if (r.sw_ofs_we)
			ofs_q <= r.sw_ofs;
		else if (r.advance)
			ofs_q <= (ofs_q == r.depth) ? OFS_RESET : ofs_q + 1'b1;

	always_ff @(posedge clock)
		if (rst)
			tally_q <= TALLY_RESET;
		else if (r.sw_tally_we)
			tally_q <= r.sw_tally;
		else if (r.pkt_done)
			tally_q <= tally_q + 1'b1;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	ring_wrap_a: assert property (
		r.advance && !r.sw_ofs_we && ofs_q == r.depth |=> ofs_q == OFS_RESET)
		else $error("pointer did not wrap to zero after depth");
	ring_step_a: assert property (
		r.advance && !r.sw_ofs_we && ofs_q != r.depth
		|=> ofs_q == $past(ofs_q) + 1'b1)
		else $error("pointer did not step by one byte");
endmodule
`default_nettype wire

// [core/acbd_core.sv]
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module acbd_core
	import acbd_pkg::*;
(
	input  wire logic              clock,        // System clock, 100 MHz.
	input  wire logic              rst,          // Sync reset, active high.
	input  wire logic              psel,         // APB select.
	input  wire logic              penable,      // APB access phase.
	input  wire logic              pwrite,       // APB write direction.
	input  wire logic [ADDR_W-1:0] paddr,        // APB byte address.
	input  wire logic [DATA_W-1:0] pwdata,       // APB write data.
	output logic      [DATA_W-1:0] prdata,       // APB read data.
	output logic                   pready,       // APB ready.
	output logic                   pslverr,      // APB unmapped address.
	input  wire logic              rd_byte_req,  // DMA wants to read a byte.
	output logic                   rd_byte_ok,   // Read byte accepted.
	input  wire logic              rd_pkt_end,   // DMA finished a read packet.
	input  wire logic              wr_byte_req,  // DMA wants to write a byte.
	output logic                   wr_byte_ok,   // Write byte accepted.
	input  wire logic              wr_pkt_end,   // DMA finished a write packet.
	input  wire logic              rx_protocol_fault_reply, // Fault reply.
	input  wire logic              rx_break_command,        // Break command.
	input  wire logic              wr_cmd_fault, // Command protocol error.
	output logic      [BA_W-1:0]   dma_rd_addr,  // Buffer RAM read address.
	output logic      [BA_W-1:0]   dma_wr_addr,  // Buffer RAM write address.
	output logic      [BA_W-1:0]   buf_last_addr, // Last byte of the ring.
	output logic                   buf_empty,    // Ring holds no data.
	output logic                   buf_full,     // Ring has no free byte.
	output logic                   irq           // Level interrupt.
);
	////////////////////////////////////////////////////////////////////////
	logic [BA_W-1:0]    base_q;
	acbd_ofs_t          depth_q;
	logic [STATE_W-1:0] rd_state_code_q;
	logic [STATE_W-1:0] wr_state_code_q;
	logic [EVT_W-1:0]   irq_sts_q;
	logic [EVT_W-1:0]   irq_en_q;
	logic [DATA_W-1:0]  prdata_q;
	logic               pslverr_q;
	logic [DATA_W-1:0]  rd_mux;
	logic               mapped;
	logic               setup;
	logic               wr_acc;
	logic [EVT_W-1:0]   evt;
	logic [STATE_W-1:0] rd_set;
	logic [STATE_W-1:0] wr_set;
	logic               same_ofs;

	acbd_ring_if rd_if ();
	acbd_ring_if wr_if ();

	acbd_ring u_rd (
		.clock (clock),
		.rst   (rst),
		.r     (rd_if)
	);
	acbd_ring u_wr (
		.clock (clock),
		.rst   (rst),
		.r     (wr_if)
	);

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states; read data is captured in the setup
	// cycle so that prdata comes straight from a flip-flop.
	assign setup   = psel && !penable;
	assign wr_acc  = psel && penable && pwrite;
	assign pready  = psel && penable;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	always_comb
	begin
		mapped = 1'b1;
		rd_mux = '0;
		case (paddr)
			OFF_BASE:    rd_mux[BA_W-1:0] = base_q;
			OFF_DEPTH:   rd_mux[DEPTH_W-1:0] = depth_q;
			OFF_RD_OFS:  rd_mux[DEPTH_W-1:0] = rd_if.ofs;
			OFF_WR_OFS:  rd_mux[DEPTH_W-1:0] = wr_if.ofs;
			OFF_TALLY:
			begin
				rd_mux[TALLY_W-1:0] = rd_if.tally;
				rd_mux[HI_LSB +: TALLY_W] = wr_if.tally;
			end
			OFF_STATE:
			begin
				rd_mux[STATE_W-1:0] = rd_state_code_q;
				rd_mux[HI_LSB +: STATE_W] = wr_state_code_q;
			end
			OFF_IRQ_STS: rd_mux[EVT_W-1:0] = irq_sts_q;
			OFF_IRQ_CLR: rd_mux = '0;
			OFF_IRQ_EN:  rd_mux[EVT_W-1:0] = irq_en_q;
			OFF_FLAGS:
			begin
				rd_mux[FLAG_EMPTY_BIT] = buf_empty;
				rd_mux[FLAG_FULL_BIT] = buf_full;
			end
			default:     mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clock)
		if (rst)
		begin
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q  <= pwrite ? '0 : rd_mux;
			pslverr_q <= !mapped;
		end

	////////////////////////////////////////////////////////////////////////
	// Descriptor configuration.
	always_ff @(posedge clock)
		if (rst)
			base_q <= '0;
		else if (wr_acc && paddr == OFF_BASE)
			base_q <= pwdata[BA_W-1:0];

	always_ff @(posedge clock)
		if (rst)
			depth_q <= OFS_RESET;
		else if (wr_acc && paddr == OFF_DEPTH)
			depth_q <= pwdata[DEPTH_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Ring pointers. A byte request is refused while the ring cannot
	// serve it, so the DMA stalls instead of overrunning data.
	assign same_ofs   = rd_if.ofs == wr_if.ofs;
	assign buf_empty  = same_ofs && rd_if.tally == wr_if.tally;
	assign buf_full   = same_ofs && rd_if.tally != wr_if.tally;
	assign rd_byte_ok = rd_byte_req && !buf_empty;
	assign wr_byte_ok = wr_byte_req && !buf_full;

	assign rd_if.depth       = depth_q;
	assign rd_if.advance     = rd_byte_ok;
	assign rd_if.pkt_done    = rd_pkt_end;
	assign rd_if.sw_ofs_we   = wr_acc && paddr == OFF_RD_OFS;
	assign rd_if.sw_ofs      = pwdata[DEPTH_W-1:0];
	assign rd_if.sw_tally_we = wr_acc && paddr == OFF_TALLY;
	assign rd_if.sw_tally    = pwdata[TALLY_W-1:0];

	assign wr_if.depth       = depth_q;
	assign wr_if.advance     = wr_byte_ok;
	assign wr_if.pkt_done    = wr_pkt_end;
	assign wr_if.sw_ofs_we   = wr_acc && paddr == OFF_WR_OFS;
	assign wr_if.sw_ofs      = pwdata[DEPTH_W-1:0];
	assign wr_if.sw_tally_we = wr_acc && paddr == OFF_TALLY;
	assign wr_if.sw_tally    = pwdata[HI_LSB +: TALLY_W];

	// Addresses wrap inside the 16 KB buffer RAM by width alone.
	assign dma_rd_addr   = base_q + BA_W'(rd_if.ofs);
	assign dma_wr_addr   = base_q + BA_W'(wr_if.ofs);
	assign buf_last_addr = base_q + BA_W'(depth_q);

	////////////////////////////////////////////////////////////////////////
	// State codes: a hardware event sets its bit even in the cycle in
	// which software rewrites the code.
	always_comb
	begin
		rd_set = STATE_RESET;
		wr_set = STATE_RESET;
		rd_set[STATE_PROTO_BIT] = rx_protocol_fault_reply;
		rd_set[STATE_BREAK_BIT] = rx_break_command;
		wr_set[STATE_PROTO_BIT] = wr_cmd_fault;
	end

	always_ff @(posedge clock)
		if (rst)
			rd_state_code_q <= STATE_RESET;
		else if (wr_acc && paddr == OFF_STATE)
			rd_state_code_q <= pwdata[STATE_W-1:0] | rd_set;
		else
			rd_state_code_q <= rd_state_code_q | rd_set;

	always_ff @(posedge clock)
		if (rst)
			wr_state_code_q <= STATE_RESET;
		else if (wr_acc && paddr == OFF_STATE)
			wr_state_code_q <= pwdata[HI_LSB +: STATE_W] | wr_set;
		else
			wr_state_code_q <= wr_state_code_q | wr_set;

	////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky status, write-one-to-clear, set beats clear.
	always_comb
	begin
		evt = EVT_RESET;
		evt[EVT_RX_FAULT] = rx_protocol_fault_reply;
		evt[EVT_RX_BREAK] = rx_break_command;
		evt[EVT_WR_FAULT] = wr_cmd_fault;
		evt[EVT_RD_PKT]   = rd_pkt_end;
		evt[EVT_WR_PKT]   = wr_pkt_end;
	end

	always_ff @(posedge clock)
		if (rst)
			irq_sts_q <= EVT_RESET;
		else if (wr_acc && paddr == OFF_IRQ_CLR)
			irq_sts_q <= (irq_sts_q & ~pwdata[EVT_W-1:0]) | evt;
		else
			irq_sts_q <= irq_sts_q | evt;

	always_ff @(posedge clock)
		if (rst)
			irq_en_q <= EVT_RESET;
		else if (wr_acc && paddr == OFF_IRQ_EN)
			irq_en_q <= pwdata[EVT_W-1:0];

	assign irq = |(irq_sts_q & irq_en_q);

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence apb_write(logic [ADDR_W-1:0] off);
		psel && penable && pwrite && paddr == off;
	endsequence

	sequence rd_step;
		rd_byte_ok && !rd_if.sw_ofs_we && rd_if.ofs != depth_q
		&& !(wr_acc && (paddr == OFF_BASE || paddr == OFF_DEPTH));
	endsequence

	sequence wr_step;
		wr_byte_ok && !wr_if.sw_ofs_we && wr_if.ofs != depth_q
		&& !(wr_acc && (paddr == OFF_BASE || paddr == OFF_DEPTH));
	endsequence

	base_write_a: assert property (
		apb_write(OFF_BASE) |=> base_q == $past(pwdata[BA_W-1:0]))
		else $error("base address not taken from write data");
	depth_end_a: assert property (
		apb_write(OFF_DEPTH)
		|=> buf_last_addr == base_q + BA_W'($past(pwdata[DEPTH_W-1:0])))
		else $error("last address is not base plus depth");
	ring_flags_a: assert property (
		buf_empty |-> rd_if.ofs == wr_if.ofs && !buf_full && !rd_byte_ok)
		else $error("empty flag inconsistent with pointers");
	tally_clear_a: assert property (
		apb_write(OFF_TALLY) ##0 (pwdata[HI_LSB +: TALLY_W] == '0
		&& pwdata[TALLY_W-1:0] == '0) |=> rd_if.tally == wr_if.tally)
		else $error("zeroed tallies differ");
	rd_addr_a: assert property (
		rd_step |=> dma_rd_addr == $past(dma_rd_addr) + 1'b1)
		else $error("read address did not follow read offset");
	wr_addr_a: assert property (
		wr_step |=> dma_wr_addr == $past(dma_wr_addr) + 1'b1)
		else $error("write address did not follow write offset");
	rd_break_a: assert property (
		rx_break_command |=> rd_state_code_q[STATE_BREAK_BIT]
		and irq_sts_q[EVT_RX_BREAK])
		else $error("break command not recorded");
	rd_fault_a: assert property (
		rx_protocol_fault_reply |=> rd_state_code_q[STATE_PROTO_BIT]
		and irq_sts_q[EVT_RX_FAULT])
		else $error("fault reply not recorded");
	wr_fault_a: assert property (
		wr_cmd_fault |=> wr_state_code_q[STATE_PROTO_BIT])
		else $error("command protocol error not recorded");
	irq_level_a: assert property (
		apb_write(OFF_IRQ_EN) ##1 (irq_sts_q != EVT_RESET)
		|-> irq == |(irq_sts_q & $past(pwdata[EVT_W-1:0])))
		else $error("interrupt level does not match enabled status");

	////////////////////////////////////////////////////////////////////////
	// Hardware counting is only checked while software leaves it alone.
	sequence tally_hw_only;
		!(wr_acc && paddr == OFF_TALLY);
	endsequence

	rd_tally_a: assert property (
		rd_pkt_end ##0 tally_hw_only
		|=> rd_if.tally == $past(rd_if.tally) + 1'b1)
		else $error("read packet tally did not count");
	wr_tally_a: assert property (
		wr_pkt_end ##0 tally_hw_only
		|=> wr_if.tally == $past(wr_if.tally) + 1'b1)
		else $error("write packet tally did not count");
	rd_refuse_a: assert property (
		rd_byte_req && buf_empty && !rd_if.sw_ofs_we
		|=> rd_if.ofs == $past(rd_if.ofs))
		else $error("read pointer moved on an empty ring");
	wr_refuse_a: assert property (
		wr_byte_req && buf_full && !wr_if.sw_ofs_we
		|=> wr_if.ofs == $past(wr_if.ofs))
		else $error("write pointer moved on a full ring");
	rd_code_hold_a: assert property (
		!(wr_acc && paddr == OFF_STATE) && rd_set == STATE_RESET
		|=> rd_state_code_q == $past(rd_state_code_q))
		else $error("read state code changed without cause");
	wr_code_hold_a: assert property (
		!(wr_acc && paddr == OFF_STATE) && wr_set == STATE_RESET
		|=> wr_state_code_q == $past(wr_state_code_q))
		else $error("write state code changed without cause");
	irq_clear_a: assert property (
		apb_write(OFF_IRQ_CLR) ##0 (evt == EVT_RESET)
		|=> (irq_sts_q & $past(pwdata[EVT_W-1:0])) == EVT_RESET)
		else $error("interrupt status bit not cleared");
	apb_slverr_a: assert property (
		setup && !mapped |=> pslverr && prdata == '0)
		else $error("unmapped address not flagged");
endmodule
`default_nettype wire

// [bench/acbd_dma_model.sv]
`timescale 1ns/1ns
`default_nettype none
module acbd_dma_model
	import acbd_pkg::*;
(
	input  wire logic       clock,    // System clock.
	input  wire logic       rst,      // Sync reset, active high.
	input  wire logic [7:0] rd_goal,  // Total bytes to read.
	input  wire logic [7:0] wr_goal,  // Total bytes to write.
	input  wire logic       rd_ok,    // Read byte accepted.
	input  wire logic       wr_ok,    // Write byte accepted.
	output logic            rd_req_q, // Read byte request.
	output logic            wr_req_q, // Write byte request.
	output logic      [7:0] rd_cnt_q, // Read bytes accepted.
	output logic      [7:0] wr_cnt_q  // Write bytes accepted.
);
	// A refused byte keeps its request up, as a real engine would retry.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rd_cnt_q <= 8'h00;
			rd_req_q <= 1'b0;
		end
		else
		begin
			rd_cnt_q <= rd_cnt_q + 8'(rd_req_q & rd_ok);
			rd_req_q <= (rd_cnt_q + 8'(rd_req_q & rd_ok)) != rd_goal;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_cnt_q <= 8'h00;
			wr_req_q <= 1'b0;
		end
		else
		begin
			wr_cnt_q <= wr_cnt_q + 8'(wr_req_q & wr_ok);
			wr_req_q <= (wr_cnt_q + 8'(wr_req_q & wr_ok)) != wr_goal;
		end
	end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import acbd_pkg::*;
	logic              clock, rst, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rdata_v;
	logic              err_v, rd_req, wr_req, rd_ok, wr_ok;
	logic              empty, full, irq;
	logic [EVT_W-1:0]  ev;
	logic [BA_W-1:0]   rd_addr, wr_addr, last_addr;
	logic [7:0]        rd_goal, wr_goal, rd_cnt, wr_cnt;
	int                err_total, total_checks;

	acbd_core acbd_core_i (.clock(clock), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rd_byte_req(rd_req), .rd_byte_ok(rd_ok),
		.rd_pkt_end(ev[EVT_RD_PKT]), .wr_byte_req(wr_req),
		.wr_byte_ok(wr_ok), .wr_pkt_end(ev[EVT_WR_PKT]),
		.rx_protocol_fault_reply(ev[EVT_RX_FAULT]),
		.rx_break_command(ev[EVT_RX_BREAK]), .wr_cmd_fault(ev[EVT_WR_FAULT]),
		.dma_rd_addr(rd_addr), .dma_wr_addr(wr_addr),
		.buf_last_addr(last_addr), .buf_empty(empty), .buf_full(full),
		.irq(irq));

	acbd_dma_model acbd_dma_model_i (.clock(clock), .rst(rst),
		.rd_goal(rd_goal), .wr_goal(wr_goal), .rd_ok(rd_ok), .wr_ok(wr_ok),
		.rd_req_q(rd_req), .wr_req_q(wr_req), .rd_cnt_q(rd_cnt),
		.wr_cnt_q(wr_cnt));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
		begin
			@(posedge clock);
		end
		rdata_v = prdata;
		err_v   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse(input int b);
		@(posedge clock);
		ev[b] <= 1'b1;
		@(posedge clock);
		ev <= '0;
		@(negedge clock);
	endtask

	// Waits until the engine has moved the given total of bytes.
	task automatic wait_cnt(input logic rd, input logic [7:0] goal);
		int n;
		n = 0;
		@(negedge clock);
		while (((rd ? rd_cnt : wr_cnt) !== goal) && n < 50)
		begin
			n++;
			@(negedge clock);
		end
		chk("byte count", 32'(rd ? rd_cnt : wr_cnt), 32'(goal));
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 10; i++)
		begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk("reset reg", rdata_v, (i == 9) ? 32'h1 : 32'h0);
		end
		apb(1'b0, 8'h28, 32'h0);
		chk("unmapped err", 32'(err_v), 32'h1);
		apb(1'b1, OFF_TALLY, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_ring();
		apb(1'b1, OFF_BASE, 32'h3ffe);
		apb(1'b1, OFF_DEPTH, 32'h3);
		apb(1'b0, OFF_BASE, 32'h0);
		chk("base", rdata_v, 32'h3ffe);
		chk("last addr", 32'(last_addr), 32'h1);
		@(posedge clock);
		wr_goal <= 8'd3;
		wait_cnt(1'b0, 8'd3);
		chk("wr addr", 32'(wr_addr), 32'h1);
		@(posedge clock);
		wr_goal <= 8'd4;
		wait_cnt(1'b0, 8'd4);
		chk("wr addr wrap", 32'(wr_addr), 32'h3ffe);
		pulse(EVT_WR_PKT);
		chk("full", {empty, full}, 2'b01);
		@(posedge clock);
		wr_goal <= 8'd5;
		repeat (4) @(negedge clock);
		chk("wr refused", {wr_ok, wr_cnt}, 9'h004);
		@(posedge clock);
		wr_goal <= 8'd4;
		rd_goal <= 8'd2;
		wait_cnt(1'b1, 8'd2);
		chk("rd addr", 32'(rd_addr), 32'h0);
		@(posedge clock);
		rd_goal <= 8'd4;
		wait_cnt(1'b1, 8'd4);
		chk("rd addr wrap", 32'(rd_addr), 32'h3ffe);
		pulse(EVT_RD_PKT);
		chk("empty", {empty, full}, 2'b10);
		@(posedge clock);
		rd_goal <= 8'd5;
		repeat (4) @(negedge clock);
		chk("rd refused", {rd_ok, rd_cnt}, 9'h004);
		@(posedge clock);
		rd_goal <= 8'd4;
		apb(1'b0, OFF_TALLY, 32'h0);
		chk("tallies", rdata_v, 32'h0101);
		apb(1'b0, OFF_RD_OFS, 32'h0);
		chk("rd offset", rdata_v, 32'h0);
		apb(1'b1, OFF_WR_OFS, 32'h2);
		@(negedge clock);
		chk("sw wr addr", 32'(wr_addr), 32'h0);
		apb(1'b0, OFF_FLAGS, 32'h0);
		chk("flags apart", rdata_v, 32'h0);
		apb(1'b1, OFF_WR_OFS, 32'h0);
		$display("test ring done");
	endtask

	task automatic t_events();
		apb(1'b1, OFF_IRQ_CLR, 32'h1f);
		apb(1'b1, OFF_IRQ_EN, 32'h1);
		apb(1'b1, OFF_STATE, 32'h0);
		pulse(EVT_RX_BREAK);
		chk("irq masked", 32'(irq), 32'h0);
		pulse(EVT_RX_FAULT);
		chk("irq set", 32'(irq), 32'h1);
		pulse(EVT_WR_FAULT);
		apb(1'b0, OFF_STATE, 32'h0);
		chk("state codes", rdata_v, 32'h0414);
		apb(1'b0, OFF_IRQ_STS, 32'h0);
		chk("irq status", rdata_v, 32'h7);
		apb(1'b1, OFF_IRQ_CLR, 32'h1);
		@(negedge clock);
		chk("irq cleared", 32'(irq), 32'h0);
		apb(1'b0, OFF_IRQ_CLR, 32'h0);
		chk("clear reads", rdata_v, 32'h0);
		$display("test events done");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial
	begin
		#200000;
		err_total++;
		summarize();
	end

	initial
	begin
		{rst, psel, penable, pwrite} = 4'h8;
		{paddr, pwdata, ev, rd_goal, wr_goal} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_ring();
		t_events();
		summarize();
	end
endmodule
`default_nettype wire
